// file: verilog/uiec_pkg.sv
// Purpose: shared constants for the usb interrupt enable and endpoint control block
// Assumes: axi4-lite register access, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
`default_nettype none
package uiec_pkg;
  localparam int ADDR_W = 12;
  localparam int EP_NUM = 16;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h000;
  localparam logic [11:0] ADDR_EP_BASE = 12'h040;
  // interrupt enable fields
  localparam int IE_STALL_BIT = 7;
  localparam int IE_ATTACH_BIT = 6;
  localparam int IE_RESUME_BIT = 5;
  localparam int IE_IDLE_BIT = 4;
  localparam int IE_TOKEN_BIT = 3;
  localparam int IE_FRAME_BIT = 2;
  localparam int IE_ERROR_BIT = 1;
  localparam int IE_RESET_UNPLUG_BIT = 0;
  localparam logic [7:0] IE_IMPL_MASK = 8'hff;
  localparam logic [7:0] IE_RESET = 8'h00;
  // endpoint control fields
  localparam int EP_LOW_SPEED_BIT = 7;
  localparam int EP_RETRY_DIS_BIT = 6;
  localparam int EP_CTRL_DIS_BIT = 4;
  localparam int EP_RX_BIT = 3;
  localparam int EP_TX_BIT = 2;
  localparam int EP_STALL_BIT = 1;
  localparam int EP_HSHK_BIT = 0;
  localparam logic [7:0] EP_IMPL_MASK = 8'hdf;
  localparam logic [7:0] EP_RESET = 8'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rd_wait;
    logic [11:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] irq_en;
    logic [7:0] irq_req;
    logic combined;
  } uiec_ctrl_t;
endpackage
`default_nettype wire

// file: verilog/uiec_ep_regs.sv
// Purpose: endpoint control register file with stall capture
// Assumes: write and read strobes come from the bus slave on the same clock
// Notes: read data is registered one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module uiec_ep_regs #(
  parameter int N = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [$clog2(N)-1:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [$clog2(N)-1:0] rd_idx_i,
  input wire logic [N-1:0] stall_set_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] ep0_ctrl_o,
  output logic [N-1:0] ep_receive_en_o,
  output logic [N-1:0] ep_transmit_en_o,
  output logic [N-1:0] ep_stalled_o,
  output logic [N-1:0] ep_handshake_en_o,
  output logic [N-1:0] ep_setup_ok_o
);
  typedef struct packed {
    logic [N-1:0][7:0] ep;
    logic [7:0] rd_data;
  } uiec_ep_state_t;

  uiec_ep_state_t st_r;
  uiec_ep_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int k = 0; k < N; k++) begin
      if (wr_en_i && wr_idx_i == k[$clog2(N)-1:0]) begin
        st_nxt.ep[k] = wr_data_i & uiec_pkg::EP_IMPL_MASK;
      end
      if (stall_set_i[k]) begin
        st_nxt.ep[k][uiec_pkg::EP_STALL_BIT] = 1'b1;
      end
    end
    if (rd_en_i) begin
      st_nxt.rd_data = st_r.ep[rd_idx_i];
    end
    if (rst_i) begin
      for (int k = 0; k < N; k++) begin
        st_nxt.ep[k] = uiec_pkg::EP_RESET;
      end
      st_nxt.rd_data = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    st_r <= st_nxt;
  end

  assign rd_data_o = st_r.rd_data;
  assign ep0_ctrl_o = st_r.ep[0];

  // same layout for every endpoint
  for (genvar g = 0; g < N; g++) begin : g_ep
    assign ep_receive_en_o[g] = st_r.ep[g][uiec_pkg::EP_RX_BIT];
    assign ep_transmit_en_o[g] = st_r.ep[g][uiec_pkg::EP_TX_BIT];
    assign ep_stalled_o[g] = st_r.ep[g][uiec_pkg::EP_STALL_BIT];
    assign ep_handshake_en_o[g] = st_r.ep[g][uiec_pkg::EP_HSHK_BIT];
    assign ep_setup_ok_o[g] = st_r.ep[g][uiec_pkg::EP_RX_BIT] && st_r.ep[g][uiec_pkg::EP_TX_BIT]
      && !st_r.ep[g][uiec_pkg::EP_CTRL_DIS_BIT];
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  stall_set_wins_a: assert property (stall_set_i[0] |=> ep_stalled_o[0])
    else $error("stall set lost on endpoint 0");
  gap_bit_zero_a: assert property (rd_en_i |=> rd_data_o[5] == 1'b0)
    else $error("endpoint bit 5 read as one");
endmodule
`default_nettype wire

// file: verilog/uiec_ctrl.sv
// Purpose: usb interrupt enable and endpoint control registers on axi4-lite
// Assumes: status flags come from the usb engine on clk_sys_i
// Notes:
// Operation
// - enable bits 31..8 read zero, ignore writes
// - bit 7 gates stall interrupt
// - bit 6 gates attach interrupt
// - bit 5 gates resume interrupt
// - bit 4 gates idle interrupt
// - bit 3 gates token done interrupt
// - bit 2 gates start of frame interrupt
// - bit 1 gates usb error interrupt
// - any enabled source sets combined flag
// - device mode: bit 0 gates bus reset
// - host mode: bit 0 gates unplug
// - sixteen endpoint registers, identical layout
// - endpoint bit 5, bits 31..8 read zero
// - endpoint 0 bit 7: low speed direct in host mode
// - endpoint 0 bit 6: disables nak retry
// - bit 4 refuses setup when rx and tx
// - bit 3 enables endpoint receive
// - bit 2 enables endpoint transmit
// - bit 1 stall status, read and write
// - bit 0 enables handshake packets
`timescale 1ns/100ps
`default_nettype none
module uiec_ctrl #(
  parameter int EP_N = uiec_pkg::EP_NUM
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // usb engine status
  input wire logic host_mode_i,
  input wire logic stall_flag_i,
  input wire logic attach_flag_i,
  input wire logic resume_flag_i,
  input wire logic idle_flag_i,
  input wire logic token_done_flag_i,
  input wire logic frame_start_flag_i,
  input wire logic error_flag_i,
  input wire logic bus_reset_flag_i,
  input wire logic unplug_flag_i,
  input wire logic [EP_N-1:0] ep_stall_set_i,
  // controls to the usb engine
  output logic [7:0] irq_req_o,
  output logic combined_usb_irq_flag_o,
  output logic [EP_N-1:0] ep_receive_en_o,
  output logic [EP_N-1:0] ep_transmit_en_o,
  output logic [EP_N-1:0] ep_stalled_o,
  output logic [EP_N-1:0] ep_handshake_en_o,
  output logic [EP_N-1:0] ep_setup_ok_o,
  output logic low_speed_direct_o,
  output logic nak_retry_en_o
);
  localparam int IDX_W = $clog2(EP_N);
  localparam logic [9:0] EP_WORD_LO = uiec_pkg::ADDR_EP_BASE[11:2];
  localparam logic [9:0] EP_WORD_HI = EP_WORD_LO + 10'(EP_N);

  uiec_pkg::uiec_ctrl_t st_r;
  uiec_pkg::uiec_ctrl_t st_nxt;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic [11:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic wr_is_ep;
  logic rd_is_ep;
  logic req_is_ep;
  logic [9:0] wr_word_off;
  logic [9:0] ar_word_off;
  logic [7:0] ep_rd_data;
  logic [7:0] ep0_ctrl;
  logic [7:0] irq_src;

  function automatic logic in_ep_range(input logic [11:0] a);
    in_ep_range = (a[11:2] >= EP_WORD_LO) && (a[11:2] < EP_WORD_HI);
  endfunction

  // bus handshakes
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rd_wait && !st_r.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  // write path joins address and data in either order
  assign wr_go = (st_r.aw_got || aw_hs) && (st_r.w_got || w_hs);
  assign wr_addr = st_r.aw_got ? st_r.awaddr : s_axi_awaddr;
  assign wr_byte = st_r.w_got ? st_r.wbyte : s_axi_wdata[7:0];
  assign wr_lane0 = st_r.w_got ? st_r.wlane0 : s_axi_wstrb[0];
  assign wr_is_ep = in_ep_range(wr_addr);
  assign rd_is_ep = in_ep_range(st_r.araddr);
  assign req_is_ep = in_ep_range(s_axi_araddr);
  assign wr_word_off = wr_addr[11:2] - EP_WORD_LO;
  assign ar_word_off = s_axi_araddr[11:2] - EP_WORD_LO;

  // interrupt sources, bit 0 depends on mode
  assign irq_src[uiec_pkg::IE_STALL_BIT] = stall_flag_i;
  assign irq_src[uiec_pkg::IE_ATTACH_BIT] = attach_flag_i;
  assign irq_src[uiec_pkg::IE_RESUME_BIT] = resume_flag_i;
  assign irq_src[uiec_pkg::IE_IDLE_BIT] = idle_flag_i;
  assign irq_src[uiec_pkg::IE_TOKEN_BIT] = token_done_flag_i;
  assign irq_src[uiec_pkg::IE_FRAME_BIT] = frame_start_flag_i;
  assign irq_src[uiec_pkg::IE_ERROR_BIT] = error_flag_i;
  assign irq_src[uiec_pkg::IE_RESET_UNPLUG_BIT] = host_mode_i ? unplug_flag_i : bus_reset_flag_i;

  always_comb begin
    st_nxt = st_r;
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (aw_hs) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wbyte = s_axi_wdata[7:0];
      st_nxt.wlane0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = uiec_pkg::RESP_OKAY;
      if (wr_addr[11:2] == uiec_pkg::ADDR_IRQ_EN[11:2]) begin
        if (wr_lane0) begin
          st_nxt.irq_en = wr_byte & uiec_pkg::IE_IMPL_MASK;
        end
      end else if (wr_is_ep) begin
        st_nxt.bresp = uiec_pkg::RESP_OKAY;
      end else begin
        st_nxt.bresp = uiec_pkg::RESP_SLVERR;
      end
    end
    // read path, one wait cycle for the endpoint file
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      st_nxt.rd_wait = 1'b1;
      st_nxt.araddr = s_axi_araddr;
    end
    if (st_r.rd_wait) begin
      st_nxt.rd_wait = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = uiec_pkg::RESP_OKAY;
      if (st_r.araddr[11:2] == uiec_pkg::ADDR_IRQ_EN[11:2]) begin
        st_nxt.rdata = {24'h000000, st_r.irq_en};
      end else if (rd_is_ep) begin
        st_nxt.rdata = {24'h000000, ep_rd_data};
      end else begin
        st_nxt.rdata = 32'h00000000;
        st_nxt.rresp = uiec_pkg::RESP_SLVERR;
      end
    end
    // per-source gating and combined flag
    st_nxt.irq_req = irq_src & st_r.irq_en;
    st_nxt.combined = |(irq_src & st_r.irq_en);
    if (rst_i) begin
      st_nxt = '0;
      st_nxt.irq_en = uiec_pkg::IE_RESET;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    st_r <= st_nxt;
  end

  uiec_ep_regs #(
    .N(EP_N)
  ) u_ep_regs (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr_en_i(wr_go && wr_lane0 && wr_is_ep),
    .wr_idx_i(wr_word_off[IDX_W-1:0]),
    .wr_data_i(wr_byte),
    .rd_en_i(ar_hs && req_is_ep),
    .rd_idx_i(ar_word_off[IDX_W-1:0]),
    .stall_set_i(ep_stall_set_i),
    .rd_data_o(ep_rd_data),
    .ep0_ctrl_o(ep0_ctrl),
    .ep_receive_en_o(ep_receive_en_o),
    .ep_transmit_en_o(ep_transmit_en_o),
    .ep_stalled_o(ep_stalled_o),
    .ep_handshake_en_o(ep_handshake_en_o),
    .ep_setup_ok_o(ep_setup_ok_o)
  );

  // host-only options of endpoint 0
  assign low_speed_direct_o = host_mode_i && ep0_ctrl[uiec_pkg::EP_LOW_SPEED_BIT];
  assign nak_retry_en_o = host_mode_i && !ep0_ctrl[uiec_pkg::EP_RETRY_DIS_BIT];

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign irq_req_o = st_r.irq_req;
  assign combined_usb_irq_flag_o = st_r.combined;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  property gate_p(logic src, logic en, logic req);
    (src && en) |=> req;
  endproperty

  property block_p(logic en, logic req);
    !en |=> !req;
  endproperty

  sequence ie_write_s;
    wr_go && wr_lane0 && wr_addr[11:2] == uiec_pkg::ADDR_IRQ_EN[11:2];
  endsequence

  sequence ie_read_s;
    ar_hs && s_axi_araddr[11:2] == uiec_pkg::ADDR_IRQ_EN[11:2];
  endsequence

  ie_upper_zero_a: assert property (ie_read_s ##2 s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("enable register upper bits not zero");
  ie_write_mask_a: assert property (ie_write_s |=> st_r.irq_en == $past(wr_byte))
    else $error("enable write not stored");
  stall_gate_a: assert property (gate_p(stall_flag_i, st_r.irq_en[7], irq_req_o[7]))
    else $error("stall request missing");
  attach_gate_a: assert property (gate_p(attach_flag_i, st_r.irq_en[6], irq_req_o[6]))
    else $error("attach request missing");
  resume_gate_a: assert property (gate_p(resume_flag_i, st_r.irq_en[5], irq_req_o[5]))
    else $error("resume request missing");
  idle_gate_a: assert property (gate_p(idle_flag_i, st_r.irq_en[4], irq_req_o[4]))
    else $error("idle request missing");
  token_gate_a: assert property (gate_p(token_done_flag_i, st_r.irq_en[3], irq_req_o[3]))
    else $error("token done request missing");
  frame_gate_a: assert property (gate_p(frame_start_flag_i, st_r.irq_en[2], irq_req_o[2]))
    else $error("frame start request missing");
  error_block_a: assert property (block_p(st_r.irq_en[1], irq_req_o[1]))
    else $error("error request while disabled");
  error_combined_a: assert property ((error_flag_i && st_r.irq_en[1]) |=> combined_usb_irq_flag_o)
    else $error("error did not reach combined flag");
  bus_reset_gate_a: assert property (gate_p(!host_mode_i && bus_reset_flag_i, st_r.irq_en[0], irq_req_o[0]))
    else $error("bus reset request missing");
  unplug_gate_a: assert property (gate_p(host_mode_i && unplug_flag_i, st_r.irq_en[0], irq_req_o[0]))
    else $error("unplug request missing");
  src_idle_a: assert property ((irq_src == 8'h00) |=> !combined_usb_irq_flag_o)
    else $error("combined flag without source");
  low_speed_host_a: assert property (!host_mode_i |-> !low_speed_direct_o)
    else $error("low speed option outside host mode");
  resp_after_both_a: assert property ($rose(s_axi_bvalid) |-> $past(wr_go))
    else $error("write answered before both parts");
  read_latency_a: assert property (ar_hs |-> ##2 s_axi_rvalid)
    else $error("read answer late");

  sequence wr_unmapped_s;
    wr_go && !wr_is_ep && wr_addr[11:2] != uiec_pkg::ADDR_IRQ_EN[11:2];
  endsequence

  sequence rd_unmapped_s;
    ar_hs && !req_is_ep && s_axi_araddr[11:2] != uiec_pkg::ADDR_IRQ_EN[11:2];
  endsequence

  sequence ep_read_s;
    ar_hs && req_is_ep;
  endsequence

  bvalid_hold_a: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  rvalid_hold_a: assert property ((s_axi_rvalid && !s_axi_rready)
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  bvalid_clear_a: assert property ((s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write answer not cleared");
  rvalid_clear_a: assert property ((s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read answer not cleared");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  wr_answer_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("write not answered");
  wr_slverr_a: assert property (wr_unmapped_s |=> s_axi_bresp == uiec_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  wr_okay_a: assert property ((wr_go && wr_is_ep) |=> s_axi_bresp == uiec_pkg::RESP_OKAY)
    else $error("endpoint write refused");
  rd_unmapped_a: assert property (rd_unmapped_s
    |-> ##2 (s_axi_rresp == uiec_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000))
    else $error("unmapped read not refused");
  ep_read_zero_a: assert property (ep_read_s |-> ##2 (s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[5]))
    else $error("endpoint unused bits not zero");
  ie_read_value_a: assert property (ie_read_s |-> ##2 s_axi_rdata[7:0] == $past(st_r.irq_en))
    else $error("enable register read wrong");
  ie_hold_a: assert property ((!wr_go || wr_addr[11:2] != uiec_pkg::ADDR_IRQ_EN[11:2]) |=> $stable(st_r.irq_en))
    else $error("enable register changed without write");
  stall_block_a: assert property (block_p(st_r.irq_en[7], irq_req_o[7]))
    else $error("stall request while disabled");
  attach_block_a: assert property (block_p(st_r.irq_en[6], irq_req_o[6]))
    else $error("attach request while disabled");
  resume_block_a: assert property (block_p(st_r.irq_en[5], irq_req_o[5]))
    else $error("resume request while disabled");
  idle_block_a: assert property (block_p(st_r.irq_en[4], irq_req_o[4]))
    else $error("idle request while disabled");
  token_block_a: assert property (block_p(st_r.irq_en[3], irq_req_o[3]))
    else $error("token done request while disabled");
  frame_block_a: assert property (block_p(st_r.irq_en[2], irq_req_o[2]))
    else $error("frame start request while disabled");
  error_gate_a: assert property (gate_p(error_flag_i, st_r.irq_en[1], irq_req_o[1]))
    else $error("error request missing");
  bit0_block_a: assert property (block_p(st_r.irq_en[0], irq_req_o[0]))
    else $error("bit 0 request while disabled");
  host_ignores_reset_a: assert property ((host_mode_i && !unplug_flag_i) |=> !irq_req_o[0])
    else $error("bit 0 request without unplug in host mode");
  dev_ignores_unplug_a: assert property ((!host_mode_i && !bus_reset_flag_i) |=> !irq_req_o[0])
    else $error("bit 0 request without bus reset in device mode");
  combined_needs_req_a: assert property (combined_usb_irq_flag_o |-> irq_req_o != 8'h00)
    else $error("combined flag without request");
  retry_host_a: assert property (!host_mode_i |-> !nak_retry_en_o)
    else $error("retry option outside host mode");
  low_speed_on_a: assert property ((host_mode_i && ep0_ctrl[uiec_pkg::EP_LOW_SPEED_BIT]) |-> low_speed_direct_o)
    else $error("low speed option lost");
  retry_on_a: assert property ((host_mode_i && !ep0_ctrl[uiec_pkg::EP_RETRY_DIS_BIT]) |-> nak_retry_en_o)
    else $error("retry option lost");
endmodule
`default_nettype wire

// file: verification/uiec_engine_model.sv
// Purpose: usb engine stand-in driving status flags and stall requests
// Assumes: flags are levels on clk_sys_i, bench sets events at the rising edge
// Notes: flag order is unplug, stall .. error, bus reset; stall sets leave as registered copies
`timescale 1ns/100ps
`default_nettype none
module uiec_engine_model (
  input wire logic clk_sys_i,
  input wire logic [8:0] evt_i,
  input wire logic [15:0] stall_req_i,
  output logic [8:0] flag_o,
  output logic [15:0] stall_set_o
);
  always_ff @(posedge clk_sys_i) begin
    flag_o <= evt_i;
    stall_set_o <= stall_req_i;
  end
endmodule
`default_nettype wire

// file: verification/uiec_ctrl_test.sv
// Purpose: self-checking bench for the usb enable and endpoint control registers
// Assumes: axi4-lite master driven at rising edges, ready sampled at the falling edge before
// Notes: offsets 0x000 and 0x040 + 4*n as chosen for the design
`timescale 1ns/100ps
`default_nettype none
module uiec_ctrl_test;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e; logic [1:0] r;} uiec_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, host = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [8:0] evt = 9'h000;
  logic [15:0] sreq = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid, comb, lsd, nre;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_v;
  logic [7:0] irq;
  logic [8:0] flg;
  logic [15:0] sset, rx, tx, stl, hs, sok;
  int n_mismatch = 0;
  int checks = 0;
  uiec_row_t rows[6];
  uiec_engine_model eng_u (.clk_sys_i(clk), .evt_i(evt), .stall_req_i(sreq), .flag_o(flg), .stall_set_o(sset));
  uiec_ctrl dut_u (.clk_sys_i(clk), .rst_i(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_mode_i(host),
    .stall_flag_i(flg[7]), .attach_flag_i(flg[6]), .resume_flag_i(flg[5]), .idle_flag_i(flg[4]),
    .token_done_flag_i(flg[3]), .frame_start_flag_i(flg[2]), .error_flag_i(flg[1]),
    .bus_reset_flag_i(flg[0]), .unplug_flag_i(flg[8]), .ep_stall_set_i(sset), .irq_req_o(irq),
    .combined_usb_irq_flag_o(comb), .ep_receive_en_o(rx), .ep_transmit_en_o(tx), .ep_stalled_o(stl),
    .ep_handshake_en_o(hs), .ep_setup_ok_o(sok), .low_speed_direct_o(lsd), .nak_retry_en_o(nre));
  always #2 clk = ~clk;
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ak, wk, ad, wd, bk;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    bk = 1'b0;
    while (!(ad && wd)) begin
      @(negedge clk);
      ak = awvalid && awready;
      wk = wvalid && wready;
      @(posedge clk);
      if (ak) awvalid <= 1'b0;
      if (wk) wvalid <= 1'b0;
      ad = ad | ak;
      wd = wd | wk;
    end
    bready <= 1'b1;
    while (!bk) begin
      @(negedge clk);
      bk = bvalid;
      rsp = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    logic ok;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clk);
      ok = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clk);
      ok = rvalid;
      rd_v = rdata;
      rsp = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask
  task irq_chk(input logic [8:0] e, input logic [7:0] x);
    @(posedge clk);
    evt <= e;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq_req", {24'h0, x}, {24'h0, irq});
    chk("combined", {31'h0, |x}, {31'h0, comb});
  endtask
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    rows = '{'{12'h000, 32'hffffffff, 4'hf, 32'h000000ff, uiec_pkg::RESP_OKAY},
      '{12'h000, 32'h0000005a, 4'h0, 32'h000000ff, uiec_pkg::RESP_OKAY},
      '{12'h040, 32'hffffffff, 4'hf, 32'h000000df, uiec_pkg::RESP_OKAY},
      '{12'h07c, 32'h00000020, 4'hf, 32'h00000000, uiec_pkg::RESP_OKAY},
      '{12'h080, 32'h00000001, 4'hf, 32'h00000000, uiec_pkg::RESP_SLVERR},
      '{12'h044, 32'h000000ad, 4'h1, 32'h0000008d, uiec_pkg::RESP_OKAY}};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(12'h000);
    chk("ie_reset", 32'h0, rd_v);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].d, rows[i].s);
      chk("wr_resp", {30'h0, rows[i].r}, {30'h0, rsp});
      rd(rows[i].a);
      chk("rd_data", rows[i].e, rd_v);
      chk("rd_resp", {30'h0, rows[i].r}, {30'h0, rsp});
    end
    $display("test table done");
    for (int i = 0; i < 16; i++) begin
      wr(12'h040 + 12'(4 * i), (i % 2) ? 32'h1f : 32'h0f, 4'hf);
      rd(12'h040 + 12'(4 * i));
      chk("ep_data", (i % 2) ? 32'h1f : 32'h0f, rd_v);
    end
    @(negedge clk);
    chk("rx_en", 32'hffff, {16'h0, rx});
    chk("tx_en", 32'hffff, {16'h0, tx});
    chk("hshk_en", 32'hffff, {16'h0, hs});
    chk("setup_ok", 32'h5555, {16'h0, sok});
    wr(12'h048, 32'h08, 4'hf);
    @(negedge clk);
    chk("setup_ok", 32'h5551, {16'h0, sok});
    chk("tx_en", 32'hfffb, {16'h0, tx});
    chk("hshk_en", 32'hfffb, {16'h0, hs});
    $display("test endpoints done");
    wr(12'h054, 32'h0d, 4'hf);
    @(negedge clk);
    chk("stalled", 32'hffdb, {16'h0, stl});
    @(posedge clk);
    sreq <= 16'h0020;
    @(posedge clk);
    sreq <= 16'h0000;
    @(posedge clk);
    @(negedge clk);
    chk("stalled", 32'hfffb, {16'h0, stl});
    rd(12'h054);
    chk("ep_data", 32'h0f, rd_v);
    $display("test stall done");
    for (int b = 0; b < 8; b++) begin
      wr(12'h000, 32'(1 << b), 4'hf);
      irq_chk(9'h0ff, 8'(1 << b));
      irq_chk(9'h1ff & ~9'(1 << b), 8'h00);
    end
    $display("test irq done");
    @(posedge clk);
    host <= 1'b1;
    wr(12'h000, 32'h01, 4'hf);
    irq_chk(9'h100, 8'h01);
    irq_chk(9'h0ff, 8'h00);
    wr(12'h040, 32'h80, 4'hf);
    @(negedge clk);
    chk("ep0_host", 32'h3, {30'h0, lsd, nre});
    wr(12'h040, 32'hc0, 4'hf);
    @(negedge clk);
    chk("ep0_host", 32'h2, {30'h0, lsd, nre});
    @(posedge clk);
    host <= 1'b0;
    @(negedge clk);
    chk("ep0_dev", 32'h0, {30'h0, lsd, nre});
    $display("test host done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(12'h040);
    chk("ep_reset", 32'h0, rd_v);
    chk("irq_reset", 32'h0, {24'h0, irq});
    chk("stall_reset", 32'h0, {16'h0, stl});
    $display("test reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
